//--- ccl_defines.svh
// register offsets, field positions, reset values and timing counts for the
// channel check logic; assumes a 32-bit apb slave with byte addresses
`ifndef CCL_DEFINES_SVH
`define CCL_DEFINES_SVH
`define CCL_OFF_CTRL     12'h000
`define CCL_OFF_STATUS   12'h004
`define CCL_OFF_CLEAR    12'h008
`define CCL_CTRL_RST     32'h0000_0001
`define CCL_CTRL_EN_BIT  0
`define CCL_F_PROGRAM_FAULT       0
`define CCL_F_CCF        4
`define CCL_F_ICF        8
`define CCL_F_WRONG      12
`define CCL_F_EARLY      16
`define CCL_F_CHKRST     20
`define CCL_NSUB         4
`define CCL_CLK_NS       5
`define CCL_STAGE_NS     20000
`define CCL_STAGE_CYC    (`CCL_STAGE_NS / `CCL_CLK_NS)
`endif

//--- ccl_pkg.sv
// types shared by the channel check logic; assumes ccl_defines.svh
package ccl_pkg;
  typedef enum logic [2:0] {
    CCL_PH_IDLE      = 3'h0,
    CCL_PH_CAW       = 3'h1,
    CCL_PH_CCW_START = 3'h3,
    CCL_PH_CCW_CHAIN = 3'h2,
    CCL_PH_READ      = 3'h6,
    CCL_PH_WRITE     = 3'h7
  } ccl_phase_e;
  typedef struct packed {
    ccl_phase_e  phase;
    logic        addr_invalid;
    logic        cpu_error;
    logic        sdr_parity_err;
    logic        cycle_ctrl_check;
    logic        cmd_parity_err;
    logic        fetch_done;
    logic        buf_load;
    logic        count_zero;
    logic [2:0]  caw_low3;
    logic [3:0]  byte_ctrl;
    logic        mc_test;
    logic [1:0]  sub;
  } ccl_proc_s;
  typedef struct packed {
    logic        bus_in_perr;
    logic        mismatch;
    logic        tag_timeout;
    logic        reselect_chain;
  } ccl_ifc_s;
endpackage

//--- ccl_check.sv
// channel check logic: program, channel control and interface control
// latches per subchannel, machine check request and timed check reset.
// assumes processor signals on pclk; interface tags arrive as raw pins.
// What this block does
// - out-of-range address on chaining fetch or read sets program fault latch
// - out-of-range read loads all four storage bytes
// - chaining fetch bad address: fault, end after fetch
// - read bad address: fault, stop on service-in
// - write bad address sets early fault flag
// - early flag plus buffer load sets wrong-data
// - wrong-data faults on service-in unless count zero
// - fetch errors, parity, cycle check set program fault
// - malfunction fault ends operation after command fetch
// - unmasked: finish fetch, test, store status, end
// - listed malfunctions set channel control fault
// - channel control fault requests machine check
// - bus-in parity or tag overlap sets interface fault
// - mismatch, timeout, reselect select-in set interface fault
// - interface fault requests machine check
// - machine check test starts check reset, clears timer
// - check reset lasts 20 to 40 microseconds
// - second timer stage ends check reset
// - check reset blocks cycle counter advance
// - address word low three bits nonzero faults
`timescale 1ns/1ps
`include "ccl_defines.svh"
module ccl_check (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire ccl_pkg::ccl_proc_s proc,
  input  wire ccl_pkg::ccl_ifc_s  ifc,
  input  wire logic              address_in,
  input  wire logic              status_in,
  input  wire logic              service_in,
  input  wire logic              select_in,
  output logic [3:0]             sdr_byte_en,
  output logic                   mc_request,
  output logic                   command_stop,
  output logic                   op_end,
  output logic                   status_store,
  output logic                   bus_out_gate,
  output logic                   check_reset,
  output logic                   cycle_adv_block
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] onehot(input logic [1:0] s);
    onehot = 4'h1 << s;
  endfunction
  function automatic logic two_of_three(input logic a, input logic b,
                                        input logic c);
    two_of_three = (a & b) | (a & c) | (b & c);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // two flops per tag pin; only stage two feeds logic
  logic [3:0] tag_s1_q;
  logic [3:0] tag_s2_q;
  logic       svc_d1_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tag_s1_q <= 4'h0;
      tag_s2_q <= 4'h0;
      svc_d1_q <= 1'b0;
    end
    else
    begin
      tag_s1_q <= {select_in, service_in, status_in, address_in};
      tag_s2_q <= tag_s1_q;
      svc_d1_q <= tag_s2_q[2];
    end
  logic adr_in, sts_in, svc_in, sel_in, svc_rise;
  assign adr_in   = tag_s2_q[0];
  assign sts_in   = tag_s2_q[1];
  assign svc_in   = tag_s2_q[2];
  assign sel_in   = tag_s2_q[3];
  assign svc_rise = svc_in & ~svc_d1_q;
  ////////////////////////////////////////////////////////////////////////////
  // apb slave; pready in the first cycle of the access phase, no wait states
  logic [31:0] ctrl_q;
  logic [31:0] clr_w;
  logic        acc, wr, chk_en;
  logic [3:0]  program_fault_q, ccf_q, icf_q, wrong_q, early_q;
  assign acc    = psel & penable & pready;
  assign wr     = acc & pwrite;
  assign chk_en = ctrl_q[`CCL_CTRL_EN_BIT];
  assign clr_w  = (wr && paddr == `CCL_OFF_CLEAR) ? pwdata : 32'h0;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctrl_q <= `CCL_CTRL_RST;
    else if (wr && paddr == `CCL_OFF_CTRL)
      ctrl_q <= pwdata;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~(paddr == `CCL_OFF_CTRL ||
                 paddr == `CCL_OFF_STATUS || paddr == `CCL_OFF_CLEAR);
      prdata  <= 32'h0;
      if (psel && !penable && !pwrite)
        unique case (paddr)
          `CCL_OFF_CTRL:   prdata <= ctrl_q;
          `CCL_OFF_STATUS: prdata <= {11'h0, check_reset, early_q, wrong_q,
                                      icf_q, ccf_q, program_fault_q};
          default:         prdata <= 32'h0;
        endcase
    end
  ////////////////////////////////////////////////////////////////////////////
  // event decode for the addressed subchannel
  logic [3:0] sel;
  logic       ph_caw, ph_start, ph_chain, ph_ccw, ph_rd, ph_wr;
  logic       bad_adr, malf, program_fault_set, ccf_set, icf_set;
  logic       wd_stop, wd_fault;
  assign sel      = onehot(proc.sub);
  assign ph_caw   = proc.phase == ccl_pkg::CCL_PH_CAW;
  assign ph_start = proc.phase == ccl_pkg::CCL_PH_CCW_START;
  assign ph_chain = proc.phase == ccl_pkg::CCL_PH_CCW_CHAIN;
  assign ph_ccw   = ph_start | ph_chain;
  assign ph_rd    = proc.phase == ccl_pkg::CCL_PH_READ;
  assign ph_wr    = proc.phase == ccl_pkg::CCL_PH_WRITE;
  assign bad_adr  = proc.addr_invalid & chk_en;
  // malfunction cases shared by program and channel control faults
  assign malf     = chk_en & (proc.cycle_ctrl_check |
                    (proc.sdr_parity_err & ph_chain) |
                    (proc.cpu_error & (ph_caw | ph_ccw)));
  assign wd_fault = chk_en & svc_rise & |(wrong_q & sel) & ~proc.count_zero;
  assign wd_stop  = svc_rise & |(wrong_q & sel) & proc.count_zero;
  assign program_fault_set = (bad_adr & (ph_chain | ph_rd))
                  | malf
                  | (chk_en & ph_caw & proc.caw_low3 != 3'h0)
                  | wd_fault;
  assign ccf_set  = malf | (chk_en & proc.cmd_parity_err);
  assign icf_set  = chk_en & ((ifc.bus_in_perr & (sts_in | adr_in)) |
                    two_of_three(adr_in, sts_in, svc_in) | ifc.mismatch |
                    ifc.tag_timeout | (sel_in & ifc.reselect_chain));
  ////////////////////////////////////////////////////////////////////////////
  // subchannel latches; set beats a software clear, check reset clears all
  logic [3:0] wipe;
  assign wipe = {4{check_reset}};
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      program_fault_q  <= 4'h0;
      ccf_q   <= 4'h0;
      icf_q   <= 4'h0;
      early_q <= 4'h0;
      wrong_q <= 4'h0;
    end
    else
    begin
      program_fault_q  <= (program_fault_q & ~clr_w[`CCL_F_PROGRAM_FAULT+:4] & ~wipe) | (sel & {4{program_fault_set}});
      ccf_q   <= (ccf_q & ~clr_w[`CCL_F_CCF+:4] & ~wipe) | (sel & {4{ccf_set}});
      icf_q   <= (icf_q & ~clr_w[`CCL_F_ICF+:4] & ~wipe) | (sel & {4{icf_set}});
      early_q <= (early_q & ~clr_w[`CCL_F_EARLY+:4] & ~wipe) |
                 (sel & {4{bad_adr & ph_wr}});
      wrong_q <= (wrong_q & ~clr_w[`CCL_F_WRONG+:4] & ~wipe) |
                 (sel & early_q & {4{proc.buf_load}});
    end
  ////////////////////////////////////////////////////////////////////////////
  // operation end, command stop and byte gating
  logic rd_pend_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      rd_pend_q <= 1'b0;
    else if (check_reset || svc_rise)
      rd_pend_q <= 1'b0;
    else if (bad_adr && ph_rd)
      rd_pend_q <= 1'b1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      command_stop <= 1'b0;
      op_end       <= 1'b0;
      status_store <= 1'b0;
      bus_out_gate <= 1'b0;
      sdr_byte_en  <= 4'h0;
    end
    else
    begin
      command_stop <= (svc_rise & rd_pend_q) | wd_stop;
      op_end       <= (proc.fetch_done & ph_ccw & |(program_fault_q & sel)) |
                      (svc_rise & rd_pend_q) | wd_stop;
      status_store <= proc.fetch_done & ph_ccw & |(program_fault_q & sel);
      // zero count keeps a stale buffer off bus out
      bus_out_gate <= svc_rise & ph_wr & ~proc.count_zero;
      // whole word loaded, then regenerated with byte gating held off
      sdr_byte_en  <= proc.addr_invalid ? 4'hf : proc.byte_ctrl;
    end
  ////////////////////////////////////////////////////////////////////////////
  // machine check request and check reset timer
  logic [11:0] presc_q;
  logic        tick, tmr1_q, tmr2_q, start;
  assign tick  = presc_q == 12'(`CCL_STAGE_CYC - 1);
  assign start = proc.mc_test & ~check_reset & |(ccf_q | icf_q);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mc_request <= 1'b0;
    else
      mc_request <= |(ccf_q | icf_q);
  // free-running divider: first tick lands anywhere in one stage period
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      presc_q <= 12'h000;
    else
      presc_q <= tick ? 12'h000 : presc_q + 12'h001;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tmr1_q <= 1'b0;
      tmr2_q <= 1'b0;
    end
    else if (start)
    begin
      tmr1_q <= 1'b0;
      tmr2_q <= 1'b0;
    end
    else if (check_reset && tick)
    begin
      tmr1_q <= 1'b1;
      tmr2_q <= tmr1_q;
    end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      check_reset     <= 1'b0;
      cycle_adv_block <= 1'b0;
    end
    else if (start)
    begin
      check_reset     <= 1'b1;
      cycle_adv_block <= 1'b1;
    end
    else if (tmr2_q)
    begin
      check_reset     <= 1'b0;
      cycle_adv_block <= 1'b0;
    end
  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [13:0] cr_len_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cr_len_q <= 14'h0;
    else
      cr_len_q <= check_reset ? cr_len_q + 14'h1 : 14'h0;
  chk_reset_max_a: assert property (@(posedge pclk) disable iff (!presetn)
    cr_len_q <= 14'd8003) else $error("check reset too long");
  chk_reset_min_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(check_reset) |-> $past(cr_len_q) >= 14'd4000)
    else $error("check reset too short");
  chk_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    cycle_adv_block == check_reset) else $error("advance block differs");
  mc_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ccf_q[proc.sub]) |=> mc_request) else $error("no machine check request");
  icf_tags_a: assert property (@(posedge pclk) disable iff (!presetn)
    (chk_en && !check_reset && adr_in && sts_in) |=> icf_q[$past(proc.sub)])
    else $error("tag overlap not flagged");
  wrong_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    (early_q[proc.sub] && proc.buf_load && !check_reset) |=> wrong_q[$past(proc.sub)])
    else $error("wrong data not flagged");
  stop_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_pend_q && svc_rise && !check_reset) |=> command_stop && op_end)
    else $error("no stop after bad read");
  byte_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    proc.addr_invalid |=> sdr_byte_en == 4'hf) else $error("byte gating not held");
  reset_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> check_reset ##1 !tmr2_q) else $error("check reset not started");
  end_chain_a: assert property (@(posedge pclk) disable iff (!presetn)
    (bad_adr && ph_chain && !check_reset) |=> program_fault_q[$past(proc.sub)])
    else $error("chaining bad address not faulted");
  ////////////////////////////////////////////////////////////////////////////
  // latch setting; a set beats both clears, so no reset term is needed here
  read_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    (bad_adr && ph_rd) |=> program_fault_q[$past(proc.sub)])
    else $error("bad read address not faulted");
  early_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (bad_adr && ph_wr) |=> early_q[$past(proc.sub)])
    else $error("early fault flag not set");
  wd_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    wd_fault |=> program_fault_q[$past(proc.sub)])
    else $error("wrong data not faulted");
  wd_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    wd_stop |=> command_stop && op_end && !bus_out_gate)
    else $error("zero count did not stop");
  program_fault_malf_a: assert property (@(posedge pclk) disable iff (!presetn)
    malf |=> program_fault_q[$past(proc.sub)])
    else $error("malfunction not a program fault");
  ccf_malf_a: assert property (@(posedge pclk) disable iff (!presetn)
    malf |=> ccf_q[$past(proc.sub)])
    else $error("malfunction not a channel fault");
  ccf_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
    (chk_en && proc.cmd_parity_err) |=> ccf_q[$past(proc.sub)])
    else $error("command parity not flagged");
  addr_word_a: assert property (@(posedge pclk) disable iff (!presetn)
    (chk_en && ph_caw && proc.caw_low3 != 3'h0) |=> program_fault_q[$past(proc.sub)])
    else $error("address word low bits not faulted");
  ////////////////////////////////////////////////////////////////////////////
  // interface faults: tag terms come from the synchronised tags, mismatch, timeout and parity straight from ifc
  icf_parity_a: assert property (@(posedge pclk) disable iff (!presetn)
    (chk_en && ifc.bus_in_perr && (sts_in || adr_in)) |=> icf_q[$past(proc.sub)])
    else $error("bus in parity not flagged");
  icf_link_a: assert property (@(posedge pclk) disable iff (!presetn)
    (chk_en && (ifc.mismatch || ifc.tag_timeout)) |=> icf_q[$past(proc.sub)])
    else $error("mismatch or timeout not flagged");
  icf_resel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (chk_en && sel_in && ifc.reselect_chain) |=> icf_q[$past(proc.sub)])
    else $error("select in on reselect not flagged");
  icf_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|icf_q) |=> mc_request)
    else $error("interface fault not requested");
  mc_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(|(ccf_q | icf_q)) |=> !mc_request)
    else $error("request without a fault");
  ////////////////////////////////////////////////////////////////////////////
  // operation end pulses
  fetch_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    (proc.fetch_done && ph_ccw && program_fault_q[proc.sub]) |=> op_end && status_store)
    else $error("fetch did not end operation");
  status_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_store |-> op_end)
    else $error("status stored without end");
  stop_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    command_stop |-> op_end)
    else $error("stop without end");
  ////////////////////////////////////////////////////////////////////////////
  // timer and check reset
  tmr_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> !tmr1_q && !tmr2_q)
    else $error("timer not cleared");
  reset_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    (check_reset && tmr2_q && !start) |=> !check_reset)
    else $error("check reset outlived stage two");
  ////////////////////////////////////////////////////////////////////////////
  // register bus; a pready that stayed up would double a clear write
  apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("slave error without ready");
  apb_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");
  prdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0)
    else $error("read data outside access");
  cov_gate_c: cover property (@(posedge pclk) disable iff (!presetn)
    bus_out_gate);
  cov_wrong_c: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(|wrong_q));
  cov_reset_c: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(check_reset));
  cov_stop_c: cover property (@(posedge pclk) disable iff (!presetn)
    command_stop);
  cov_end_c: cover property (@(posedge pclk) disable iff (!presetn)
    status_store);
endmodule

//--- ccl_cpu_model.sv
// processor model: latches the channel check request, takes machine check
// assumes mc_request is a level on pclk from the channel
`timescale 1ns/1ps
module ccl_cpu_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic mc_request,
  input  wire logic mask_en,
  input  wire logic take,
  output logic      mc_test
);
  ////////////////////////////////////////////////////////////////////////////
  logic req_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) req_q <= 1'b0;
    else req_q <= mc_request;
  end
  // one pulse per take, every other cycle while take is held; a masked check simply stays pending
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) mc_test <= 1'b0;
    else mc_test <= take && mask_en && req_q && !mc_test;
  end
endmodule

//--- tb_ccl_check.sv
// testbench for the channel check logic: apb master, processor and tags
// assumes ccl_defines.svh, ccl_pkg and the processor model
`timescale 1ns/1ps
`include "ccl_defines.svh"
module tb_ccl_check;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic address_in, status_in, service_in, select_in, take, mc_test, er;
  logic [3:0] sdr_byte_en;
  logic mc_request, command_stop, op_end, status_store, bus_out_gate;
  logic check_reset, cycle_adv_block;
  ccl_pkg::ccl_proc_s p, proc;
  ccl_pkg::ccl_ifc_s  ifc;
  int n_mismatch, samples_checked, n;
  always_comb
  begin
    proc = p;
    proc.mc_test = mc_test;
  end
  ccl_check u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .proc(proc), .ifc(ifc), .address_in(address_in),
    .status_in(status_in), .service_in(service_in), .select_in(select_in),
    .sdr_byte_en(sdr_byte_en), .mc_request(mc_request), .command_stop(command_stop),
    .op_end(op_end), .status_store(status_store), .bus_out_gate(bus_out_gate),
    .check_reset(check_reset), .cycle_adv_block(cycle_adv_block));
  ccl_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .mc_request(mc_request),
    .mask_en(1'b1), .take(take), .mc_test(mc_test));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic status(input logic [31:0] e, input string m);
    apb(1'b0, `CCL_OFF_STATUS, 32'h0);
    chk(rd, e, m);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // tags go through a 2 flop sync, so waits allow a few cycles of slack
  task automatic wait_pulse(ref logic s, input string m);
    n = 0;
    do begin cyc(1); n++; end while (s !== 1'b1 && n < 8);
    chk({31'h0, s}, 32'h1, m);
  endtask
  task automatic clear_all();
    p <= '0;
    apb(1'b1, `CCL_OFF_CLEAR, 32'h001f_ffff);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, `CCL_OFF_CTRL, 32'h0);
    chk(rd, `CCL_CTRL_RST, "ctrl reset");
    status(32'h0, "status reset");
    apb(1'b0, 12'h0fc, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped slverr");
  endtask
  task automatic t_read_bad();
    p.phase <= ccl_pkg::CCL_PH_READ; p.sub <= 2'h1; p.byte_ctrl <= 4'h3;
    p.addr_invalid <= 1'b1;
    cyc(2);
    chk({28'h0, sdr_byte_en}, 32'hf, "byte enables");
    p.addr_invalid <= 1'b0;
    cyc(2);
    chk({28'h0, sdr_byte_en}, 32'h3, "byte gating back");
    service_in <= 1'b1;
    wait_pulse(command_stop, "command stop");
    chk({31'h0, op_end}, 32'h1, "read op end");
    service_in <= 1'b0;
    status(32'h0000_0002, "read program_fault fault");
    clear_all();
  endtask
  task automatic t_write_bad(input logic cz);
    p.phase <= ccl_pkg::CCL_PH_WRITE; p.sub <= 2'h2; p.count_zero <= cz;
    p.addr_invalid <= 1'b1;
    cyc(1);
    p.addr_invalid <= 1'b0;
    status(32'h0004_0000, "early flag");
    p.buf_load <= 1'b1;
    cyc(1);
    p.buf_load <= 1'b0;
    status(32'h0004_4000, "wrong data");
    service_in <= 1'b1;
    if (cz)
    begin
      wait_pulse(command_stop, "zero count stop");
      chk({31'h0, bus_out_gate}, 32'h0, "no bus out at zero count");
    end
    else
      wait_pulse(bus_out_gate, "buffer on bus out");
    cyc(2);
    service_in <= 1'b0;
    status({31'h0002_2000, 1'b0} | (cz ? 32'h0 : 32'h4), "wrong data count");
    clear_all();
  endtask
  task automatic t_malfunction(input ccl_pkg::ccl_phase_e ph);
    p.phase <= ph; p.sub <= 2'h3; p.cpu_error <= 1'b1;
    cyc(1);
    p.cpu_error <= 1'b0;
    cyc(2);
    chk({31'h0, mc_request}, 32'h1, "mc request");
    status(32'h0000_0088, "malfunction latches");
    p.phase <= ccl_pkg::CCL_PH_CCW_START; p.fetch_done <= 1'b1;
    cyc(1);
    p.fetch_done <= 1'b0;
    wait_pulse(op_end, "fetch end");
    chk({31'h0, status_store}, 32'h1, "status store");
  endtask
  task automatic t_chain_caw();
    clear_all();
    p.phase <= ccl_pkg::CCL_PH_CCW_CHAIN; p.sub <= 2'h0; p.addr_invalid <= 1'b1;
    cyc(1);
    p.addr_invalid <= 1'b0;
    p.fetch_done <= 1'b1;
    cyc(1);
    p.fetch_done <= 1'b0;
    wait_pulse(op_end, "chain end");
    p.phase <= ccl_pkg::CCL_PH_CAW; p.sub <= 2'h1; p.caw_low3 <= 3'h4;
    cyc(1);
    p <= '0;
    status(32'h0000_0003, "chain and caw faults");
    clear_all();
  endtask
  task automatic t_link_faults();
    ifc.mismatch <= 1'b1;
    p.sub <= 2'h1;
    cyc(1);
    ifc.mismatch <= 1'b0;
    ifc.tag_timeout <= 1'b1;
    p.sub <= 2'h0;
    p.cycle_ctrl_check <= 1'b1;
    cyc(1);
    ifc.tag_timeout <= 1'b0;
    p.cycle_ctrl_check <= 1'b0;
    p.sub <= 2'h2;
    p.phase <= ccl_pkg::CCL_PH_CCW_CHAIN;
    p.sdr_parity_err <= 1'b1;
    p.cmd_parity_err <= 1'b1;
    cyc(1);
    p.phase <= ccl_pkg::CCL_PH_IDLE;
    p.sdr_parity_err <= 1'b0;
    p.cmd_parity_err <= 1'b0;
    p.sub <= 2'h3;
    ifc.reselect_chain <= 1'b1;
    select_in <= 1'b1;
    cyc(4);
    ifc.reselect_chain <= 1'b0;
    select_in <= 1'b0;
    cyc(3);
    chk({31'h0, mc_request}, 32'h1, "link fault request");
    status(32'h0000_0b55, "link and malfunction faults");
    clear_all();
  endtask
  task automatic t_iface_reset();
    status_in <= 1'b1; service_in <= 1'b1;
    cyc(1);
    status_in <= 1'b0; service_in <= 1'b0;
    cyc(6);
    chk({31'h0, mc_request}, 32'h1, "iface request");
    status(32'h0000_0100, "tag overlap");
    take <= 1'b1;
    cyc(1);
    take <= 1'b0;
    wait_pulse(check_reset, "check reset");
    n = 0;
    while (check_reset === 1'b1 && n < 9000)
    begin
      chk({31'h0, cycle_adv_block}, 32'h1, "advance blocked");
      cyc(1);
      n++;
    end
    chk({31'h0, n >= 3999 && n <= 8002}, 32'h1, "reset length");
    status(32'h0, "latches wiped");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
    pwdata = '0; p = '0; ifc = '0; address_in = 1'b0; status_in = 1'b0;
    service_in = 1'b0; select_in = 1'b0; take = 1'b0;
    n_mismatch = 0; samples_checked = 0;
    cyc(16);
    presetn <= 1'b1;
    cyc(3);
    t_regs();
    t_read_bad();
    t_write_bad(1'b0);
    t_write_bad(1'b1);
    t_malfunction(ccl_pkg::CCL_PH_CAW);
    t_chain_caw();
    t_link_faults();
    t_iface_reset();
    print_verdict();
  end
  // whole run is about 8000 cycles
  initial
  begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule
